//--- design/scc_pkg.sv
// Purpose: Shared constants and carriers for the conditioner register set
// Assumes: Byte-addressed register port driven by the two-wire front end
// Notes:   Offsets are the printed byte addresses
package scc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL0   = 8'h80;
  localparam logic [7:0] ADDR_TBL1    = 8'h81;
  localparam logic [7:0] ADDR_TBL2    = 8'h82;
  localparam logic [7:0] ADDR_DAC1    = 8'h83;
  localparam logic [7:0] ADDR_DAC2    = 8'h84;
  localparam logic [7:0] ADDR_SRCSEL  = 8'h85;
  localparam logic [7:0] ADDR_WGATE   = 8'h86;
  localparam logic [7:0] ADDR_RESULT  = 8'h87;
  localparam logic [7:0] TBL1_BASE    = 8'h90;
  localparam logic [7:0] TBL2_BASE    = 8'hd0;

  // ****************************************************
  // Field positions and special values
  // ****************************************************
  localparam int CTRL0_PERSIST_BIT = 5;
  localparam int CTRL0_FILTOFF_BIT = 4;
  localparam int CTRL0_INSEL_BIT   = 3;
  localparam int CTRL0_REFSEL_BIT  = 2;
  localparam int SRC_CONV2_BIT     = 7;
  localparam int SRC_TBL2_BIT      = 6;
  localparam int SRC_CONV1_BIT     = 5;
  localparam int SRC_TBL1_BIT      = 4;
  localparam int WGATE_LATCH_BIT   = 7;
  localparam logic [7:0] WGATE_SET_VAL   = 8'h80;
  localparam logic [7:0] WGATE_CLEAR_VAL = 8'h00;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [2:0] FILTER_AGREE    = 3'h4;

  // ****************************************************
  // Full-scale decode
  // ****************************************************
  typedef enum logic [1:0] {
    FS_EXTERNAL = 2'b00,
    FS_0P40MA   = 2'b01,
    FS_0P85MA   = 2'b10,
    FS_1P30MA   = 2'b11
  } scc_fullscale_type;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_req_type;

  // Register port answer
  typedef struct packed {
    logic       ack;
    logic       nak;
    logic [7:0] rdata;
  } scc_rsp_type;

endpackage

//--- design/scc_filter.sv
// Purpose: Conversion agreement filter in front of the result register
// Assumes: Sample strobe is a one-cycle pulse per finished conversion
// Notes:   Bypass updates on every sample
`timescale 1ns/1ps
module scc_filter #(
  parameter int AGREE = 4
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       bypass,
  input  wire logic       sample_vld,
  input  wire logic [7:0] sample,
  output logic            result_vld,
  output logic [7:0]      result
);

  initial begin
    if (AGREE < 1 || AGREE > 7) $error("AGREE out of range");
  end

  logic [2:0] cnt_q, cnt_d;
  logic [5:0] top_q, top_d;
  logic [7:0] res_q, res_d;
  logic       vld_q, vld_d;

  // Next-state: count agreeing conversions on the upper six bits
  always_comb begin
    cnt_d = cnt_q;
    top_d = top_q;
    res_d = res_q;
    vld_d = vld_q;
    if (sample_vld) begin
      top_d = sample[7:2];
      if (cnt_q == 3'h0 || sample[7:2] != top_q) begin
        cnt_d = 3'h1;
      end else if (cnt_q < 3'(AGREE)) begin
        cnt_d = cnt_q + 3'h1;
      end
      if (bypass || cnt_d == 3'(AGREE)) begin
        res_d = sample;
        vld_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      top_q <= 6'h00;
      res_q <= 8'h00;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      top_q <= top_d;
      res_q <= res_d;
      vld_q <= vld_d;
    end
  end

  assign result     = res_q;
  assign result_vld = vld_q;

endmodule

//--- design/scc_regs.sv
// Purpose: Upper control and status registers of the sensor conditioner
// Assumes: Byte-wide register port from the two-wire slave front end
// Notes:   Nonvolatile storage lives outside; this block only steers it
`timescale 1ns/1ps

// How it works
// - Converter-two direct value byte lives at 84h, read and write.
// - Direct value storage follows the persistence select in control zero.
// - Converter-two direct select set feeds the direct byte to converter two.
// - Direct select clear ignores the converter-two direct byte.
// - Source and full-scale select register lives at 85h, read and write.
// - Generator-one full-scale code decodes external, 0.4, 0.85, 1.3 mA.
// - Generator-two full-scale code decodes external, 0.4, 0.85, 1.3 mA.
// - Table-one row comes from result or the override field.
// - Converter-one input is table-one row or its direct byte.
// - Table-two row comes from result or the override field.
// - Write-gate register holding the latch lives at 86h.
// - Writes with latch clear, except to 86h, are dropped and not acknowledged.
// - Latch clears at reset, sets on writing 80h.
// - Latch stays set until reset or writing 00h.
// - Latch writes leave the other write-gate bits unchanged.
// - Conversion result is read-only at 87h.
// - Result is plain binary; six upper bits select table rows.
// - Filter on: update after four agreeing conversions.
// - Filter bypassed: update after every conversion.
// - Reference select picks internal or external reference.
// - Input select bit 3 picks temperature sensor or sense pin.
// - Row address is table base plus six row bits.
// - Converter input bytes stay 00h until first valid selection.
module scc_regs #(
  parameter int AGREE = 4
) (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire scc_pkg::scc_req_type    req,
  output scc_pkg::scc_rsp_type         rsp,
  input  wire logic [7:0]              ctrl0,
  input  wire logic [5:0]              table1_row_override,
  input  wire logic [5:0]              table2_row_override,
  input  wire logic [7:0]              dac1_direct_byte,
  input  wire logic                    sample_vld,
  input  wire logic [7:0]              sample,
  input  wire logic [7:0]              table1_byte,
  input  wire logic [7:0]              table2_byte,
  output logic [7:0]                   table1_addr,
  output logic [7:0]                   table2_addr,
  output logic [7:0]                   conv1_in,
  output logic [7:0]                   conv2_in,
  output scc_pkg::scc_fullscale_type   gen1_fullscale_sel,
  output scc_pkg::scc_fullscale_type   gen2_fullscale_sel,
  output logic                         reference_source_sel,
  output logic                         conversion_input_sel,
  output logic                         dac2_persist_nv,
  output logic                         write_allowed
);

  initial begin
    if (AGREE != 4) $error("Only four agreeing conversions are served");
  end

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0]                 dac2_direct_byte_q, dac2_direct_byte_d;
  logic [7:0]                 srcsel_q, srcsel_d;
  logic                       write_gate_latch_q, write_gate_latch_d;
  scc_pkg::scc_rsp_type       rsp_q, rsp_d;
  logic [7:0]                 t1a_q, t1a_d, t2a_q, t2a_d;
  logic [7:0]                 c1_q, c1_d, c2_q, c2_d;
  logic                       ref_q, ref_d, insel_q, insel_d;
  logic                       pers_q, pers_d;
  logic                       filt_vld;
  logic [7:0]                 conversion_result_bits;
  logic [5:0]                 row1, row2;
  logic                       wr_ok;

  // Row address from table base plus six-bit row
  function automatic logic [7:0] row_addr(input logic [7:0] base,
                                          input logic [5:0] row);
    row_addr = base + {2'b00, row};
  endfunction

  // Result filter
  scc_filter #(
    .AGREE      (AGREE)
  ) u_filter (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .bypass     (ctrl0[scc_pkg::CTRL0_FILTOFF_BIT]),
    .sample_vld (sample_vld),
    .sample     (sample),
    .result_vld (filt_vld),
    .result     (conversion_result_bits)
  );

  // Writes only land while the latch is set, except on the gate itself
  assign wr_ok = req.wr && (write_gate_latch_q ||
                            req.addr == scc_pkg::ADDR_WGATE);

  // ****************************************************
  // Register file next-state
  // ****************************************************
  always_comb begin
    dac2_direct_byte_d = dac2_direct_byte_q;
    srcsel_d           = srcsel_q;
    write_gate_latch_d = write_gate_latch_q;
    rsp_d              = '0;
    if (req.wr) begin
      if (!wr_ok) begin
        rsp_d.nak = 1'b1;
      end else begin
        rsp_d.ack = 1'b1;
        unique case (req.addr)
          scc_pkg::ADDR_DAC2: dac2_direct_byte_d = req.wdata;
          scc_pkg::ADDR_SRCSEL: srcsel_d = req.wdata;
          scc_pkg::ADDR_WGATE: begin
            // Only the two gate bytes act; other bits stay reserved
            if (req.wdata == scc_pkg::WGATE_SET_VAL) begin
              write_gate_latch_d = 1'b1;
            end else if (req.wdata == scc_pkg::WGATE_CLEAR_VAL) begin
              write_gate_latch_d = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end else if (req.rd) begin
      rsp_d.ack = 1'b1;
      unique case (req.addr)
        scc_pkg::ADDR_DAC2: rsp_d.rdata = dac2_direct_byte_q;
        scc_pkg::ADDR_SRCSEL: rsp_d.rdata = srcsel_q;
        scc_pkg::ADDR_WGATE:
          rsp_d.rdata = {write_gate_latch_q, 7'h00};
        scc_pkg::ADDR_RESULT: rsp_d.rdata = conversion_result_bits;
        default: rsp_d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************
  // Datapath next-state
  // ****************************************************
  always_comb begin
    // Six upper result bits pick the row unless overridden
    row1 = srcsel_q[scc_pkg::SRC_TBL1_BIT] ? table1_row_override
                                            : conversion_result_bits[7:2];
    row2 = srcsel_q[scc_pkg::SRC_TBL2_BIT] ? table2_row_override
                                            : conversion_result_bits[7:2];
    t1a_d = row_addr(scc_pkg::TBL1_BASE, row1);
    t2a_d = row_addr(scc_pkg::TBL2_BASE, row2);
    c1_d  = c1_q;
    c2_d  = c2_q;
    // Converter one: direct byte or table row
    if (srcsel_q[scc_pkg::SRC_CONV1_BIT]) begin
      c1_d = dac1_direct_byte;
    end else if (filt_vld || srcsel_q[scc_pkg::SRC_TBL1_BIT]) begin
      c1_d = table1_byte;
    end
    // Converter two: direct byte or table row
    if (srcsel_q[scc_pkg::SRC_CONV2_BIT]) begin
      c2_d = dac2_direct_byte_q;
    end else if (filt_vld || srcsel_q[scc_pkg::SRC_TBL2_BIT]) begin
      c2_d = table2_byte;
    end
    ref_d   = ctrl0[scc_pkg::CTRL0_REFSEL_BIT];
    insel_d = ctrl0[scc_pkg::CTRL0_INSEL_BIT];
    pers_d  = ctrl0[scc_pkg::CTRL0_PERSIST_BIT];
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dac2_direct_byte_q <= scc_pkg::RESET_BYTE;
      srcsel_q           <= scc_pkg::RESET_BYTE;
      write_gate_latch_q <= 1'b0;
      rsp_q              <= '0;
      t1a_q              <= scc_pkg::TBL1_BASE;
      t2a_q              <= scc_pkg::TBL2_BASE;
      c1_q               <= scc_pkg::RESET_BYTE;
      c2_q               <= scc_pkg::RESET_BYTE;
      ref_q              <= 1'b0;
      insel_q            <= 1'b0;
      pers_q             <= 1'b0;
    end else begin
      dac2_direct_byte_q <= dac2_direct_byte_d;
      srcsel_q           <= srcsel_d;
      write_gate_latch_q <= write_gate_latch_d;
      rsp_q              <= rsp_d;
      t1a_q              <= t1a_d;
      t2a_q              <= t2a_d;
      c1_q               <= c1_d;
      c2_q               <= c2_d;
      ref_q              <= ref_d;
      insel_q            <= insel_d;
      pers_q             <= pers_d;
    end
  end

  // Outputs straight from flip-flops
  assign rsp                  = rsp_q;
  assign table1_addr          = t1a_q;
  assign table2_addr          = t2a_q;
  assign conv1_in             = c1_q;
  assign conv2_in             = c2_q;
  assign gen1_fullscale_sel   =
    scc_pkg::scc_fullscale_type'(srcsel_q[1:0]);
  assign gen2_fullscale_sel   =
    scc_pkg::scc_fullscale_type'(srcsel_q[3:2]);
  assign reference_source_sel = ref_q;
  assign conversion_input_sel = insel_q;
  assign dac2_persist_nv      = pers_q;
  assign write_allowed        = write_gate_latch_q;

endmodule

//--- verif/scc_regs_properties.sv
// Purpose: Port-level checks for the conditioner register set
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to every scc_regs by the bind below
`timescale 1ns/1ps
module scc_regs_properties #(
  parameter int AGREE = 4
) (
  input wire logic                 core_clk,
  input wire logic                 nrst,
  input wire scc_pkg::scc_req_type req,
  input wire scc_pkg::scc_rsp_type rsp,
  input wire logic [7:0]           ctrl0,
  input wire logic [7:0]           table1_addr,
  input wire logic [7:0]           table2_addr,
  input wire logic                 reference_source_sel,
  input wire logic                 conversion_input_sel,
  input wire logic                 dac2_persist_nv,
  input wire logic                 write_allowed
);
  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Write aimed at the write-gate register
  logic gate_wr;
  assign gate_wr = req.wr && req.addr == scc_pkg::ADDR_WGATE;
  a_nak_when_closed: assert property (req.wr && !gate_wr && !write_allowed
    |=> rsp.nak && !rsp.ack) else $error("closed write not refused");
  a_latch_set: assert property (gate_wr && req.wdata == 8'h80
    |=> write_allowed) else $error("latch not set");
  a_latch_clear: assert property (gate_wr && req.wdata == 8'h00
    |=> !write_allowed) else $error("latch not cleared");
  a_latch_holds: assert property (!(gate_wr && (req.wdata == 8'h80
    || req.wdata == 8'h00)) |=> $stable(write_allowed))
    else $error("latch moved");
  a_read_acked: assert property (req.rd && !req.wr |=> rsp.ack && !rsp.nak)
    else $error("read not acked");
  a_gate_read: assert property (req.rd && !req.wr && !gate_wr
    && req.addr == scc_pkg::ADDR_WGATE
    |=> rsp.rdata == {$past(write_allowed), 7'h00})
    else $error("gate read wrong");
  a_row_range: assert property (table1_addr >= scc_pkg::TBL1_BASE
    && table1_addr <= 8'hcf && table2_addr >= scc_pkg::TBL2_BASE)
    else $error("row address out of table");
  a_ref_follows: assert property ($past(nrst)
    |-> reference_source_sel == $past(ctrl0[2]))
    else $error("reference select lag");
  a_input_follows: assert property ($past(nrst)
    |-> conversion_input_sel == $past(ctrl0[3]))
    else $error("input select lag");
  a_persist_follows: assert property ($past(nrst)
    |-> dac2_persist_nv == $past(ctrl0[5]))
    else $error("persistence lag");
endmodule
bind scc_regs scc_regs_properties #(.AGREE(AGREE)) u_chk (.core_clk, .nrst,
  .req, .rsp, .ctrl0, .table1_addr, .table2_addr, .reference_source_sel,
  .conversion_input_sel, .dac2_persist_nv, .write_allowed);

//--- verif/scc_master.sv
// Purpose: Two-wire master stand-in issuing single-byte register requests
// Assumes: Answer comes one cycle after the request edge
// Notes:   Idle address and data lines carry the inverse of the last ones
`timescale 1ns/1ps
module scc_master (
  input  wire logic                 core_clk,
  input  wire scc_pkg::scc_rsp_type rsp,
  output scc_pkg::scc_req_type      req
);
  logic [7:0] got;
  logic       nak;
  logic       ack;
  initial req = '0;
  // ****************************************************
  // One byte per transfer
  // ****************************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    got = rsp.rdata;
    nak = rsp.nak;
    ack = rsp.ack;
  endtask
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the conditioner register set
// Assumes: Table memory answers combinationally from the row address
// Notes:   Random bytes from a shift register with a fixed seed
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  scc_pkg::scc_req_type req;
  scc_pkg::scc_rsp_type rsp;
  scc_pkg::scc_fullscale_type gen1_fullscale_sel, gen2_fullscale_sel;
  logic [7:0] ctrl0, dac1_direct_byte, sample, table1_byte, table2_byte;
  logic [7:0] table1_addr, table2_addr, conv1_in, conv2_in, v, d2;
  logic [5:0] table1_row_override, table2_row_override;
  logic       sample_vld, reference_source_sel, conversion_input_sel;
  logic       dac2_persist_nv, write_allowed;
  logic [31:0] rnd = 32'hc0e2_1b72;
  int error_cnt = 0;
  int n_tests = 0;
  // ****************************************************
  // Clock, table memory, instances
  // ****************************************************
  always #5 core_clk = ~core_clk;
  assign table1_byte = mem(table1_addr);
  assign table2_byte = mem(table2_addr);
  scc_master u_mst (.core_clk, .rsp, .req);
  scc_regs #(.AGREE(4)) u_dut (.core_clk, .nrst, .req, .rsp, .ctrl0,
    .table1_row_override, .table2_row_override, .dac1_direct_byte,
    .sample_vld, .sample, .table1_byte, .table2_byte, .table1_addr,
    .table2_addr, .conv1_in, .conv2_in, .gen1_fullscale_sel,
    .gen2_fullscale_sel, .reference_source_sel, .conversion_input_sel,
    .dac2_persist_nv, .write_allowed);
  function automatic logic [7:0] mem(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  function automatic logic [7:0] row(input logic [7:0] b, input logic [5:0] r);
    return b + {2'h0, r};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
    u_mst.xfer(1'b1, a, d);
    chk("refusal", {7'h00, k}, {7'h00, u_mst.nak});
    chk("write ack", {7'h00, !k}, {7'h00, u_mst.ack});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_mst.xfer(1'b0, a, 8'h00);
    chk("read data", e, u_mst.got);
    chk("read ack", 8'h01, {7'h00, u_mst.ack});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input logic [7:0] s);
    sample_vld = 1'b1;
    sample = s;
    cyc(1);
    sample_vld = 1'b0;
    sample = ~s;
    cyc(2);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end
  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    {ctrl0, dac1_direct_byte, sample, sample_vld} = '0;
    {table1_row_override, table2_row_override} = '0;
    cyc(12);
    nrst = 1'b1;
    cyc(1);
    chk("latch", 8'h00, {7'h00, write_allowed});
    chk("conv1", 8'h00, conv1_in);
    chk("conv2", 8'h00, conv2_in);
    chk("gen1 reset", 8'h00, {6'h00, gen1_fullscale_sel});
    chk("gen2 reset", 8'h00, {6'h00, gen2_fullscale_sel});
    wr(8'h84, 8'h3c, 1'b1);
    wr(8'h86, 8'h80, 1'b0);
    rd(8'h84, 8'h00);
    wr(8'h86, 8'h55, 1'b0);
    rd(8'h86, 8'h80);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d2 = rnd[7:0];
      wr(8'h84, d2, 1'b0);
      rd(8'h84, d2);
      wr(8'h85, {4'h0, ~i[1:0], i[1:0]}, 1'b0);
      rd(8'h85, {4'h0, ~i[1:0], i[1:0]});
      chk("gen1", {6'h00, i[1:0]}, {6'h00, gen1_fullscale_sel});
      chk("gen2", {6'h00, ~i[1:0]}, {6'h00, gen2_fullscale_sel});
    end
    v = rnd[15:8];
    for (int k = 0; k < 3; k++) pulse(v ^ k[7:0]);
    pulse(v ^ 8'h80);
    for (int k = 0; k < 3; k++) pulse(v);
    rd(8'h87, 8'h00);
    chk("conv1 idle", 8'h00, conv1_in);
    chk("conv2 idle", 8'h00, conv2_in);
    v = v ^ 8'h03;
    pulse(v);
    rd(8'h87, v);
    chk("row1", row(scc_pkg::TBL1_BASE, v[7:2]), table1_addr);
    chk("row2", row(scc_pkg::TBL2_BASE, v[7:2]), table2_addr);
    chk("conv1", mem(row(scc_pkg::TBL1_BASE, v[7:2])), conv1_in);
    chk("conv2", mem(row(scc_pkg::TBL2_BASE, v[7:2])), conv2_in);
    ctrl0 = rnd[23:16] | 8'h10;
    table1_row_override = rnd[29:24];
    table2_row_override = rnd[5:0];
    dac1_direct_byte = rnd[31:24];
    cyc(2);
    chk("persist", {7'h00, ctrl0[5]}, {7'h00, dac2_persist_nv});
    chk("insel", {7'h00, ctrl0[3]}, {7'h00, conversion_input_sel});
    chk("refsel", {7'h00, ctrl0[2]}, {7'h00, reference_source_sel});
    pulse(~v);
    rd(8'h87, ~v);
    wr(8'h85, 8'h50, 1'b0);
    cyc(3);
    chk("row1 override", row(8'h90, table1_row_override), table1_addr);
    chk("row2 override", row(8'hd0, table2_row_override), table2_addr);
    chk("conv1 row", mem(row(8'h90, table1_row_override)), conv1_in);
    chk("conv2 row", mem(row(8'hd0, table2_row_override)), conv2_in);
    wr(8'h85, 8'ha0, 1'b0);
    cyc(3);
    chk("conv1 direct", dac1_direct_byte, conv1_in);
    chk("conv2 direct", d2, conv2_in);
    wr(8'h87, 8'hff, 1'b0);
    rd(8'h87, ~v);
    rd(8'h8a, 8'h00);
    wr(8'h86, 8'h00, 1'b0);
    chk("latch", 8'h00, {7'h00, write_allowed});
    wr(8'h85, 8'h00, 1'b1);
    rd(8'h85, 8'ha0);
    // Power cycle in mid-run: latch and converter inputs fall back
    wr(8'h86, 8'h80, 1'b0);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    chk("latch after reset", 8'h00, {7'h00, write_allowed});
    chk("conv1 after reset", 8'h00, conv1_in);
    chk("conv2 after reset", 8'h00, conv2_in);
    chk("row1 after reset", scc_pkg::TBL1_BASE, table1_addr);
    wr(8'h84, 8'h5a, 1'b1);
    give_verdict();
  end
endmodule
